// ### design/lsa_pkg.sv
// Package: constants and carrier types for the LMFC/SYSREF alignment status block
// Function
// - Status bit 7 shows busy while the alignment state machine is not idle.
// - Status bit 3 shows lock while aligned with error inside the window.
// - Status bit 2 is set sticky whenever the multiframe clock is shifted.
// - Status bit 1 is high while the error measured in monitor lies outside the window; an adjustment clears it.
// - Status bit 0 is set sticky on a reference pulse received after arming.
// - Current error field [3:0] is a 4-bit two's complement cycle count.
// - On an adjustment the error goes to the last record; current reads zero.
// - Errors within plus or minus the two-bit window cause no adjustment.
// - A rising edge of the sticky-clear bit clears rotated and tripped flags.
// - Mode codes: one-shot 0001, continuous 0010, monitor 1000, one-shot then monitor 1001.
package lsa_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LSA_ADDR_STATUS  = 12'h03c;
  localparam logic [11:0] LSA_ADDR_ERR_NOW = 12'h03d;
  localparam logic [7:0]  LSA_STATUS_RST   = 8'h00;
  localparam logic [7:0]  LSA_ERR_NOW_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LSA_BIT_BUSY    = 7;
  localparam int LSA_BIT_LOCK    = 3;
  localparam int LSA_BIT_ROTATED = 2;
  localparam int LSA_BIT_WLIM    = 1;
  localparam int LSA_BIT_TRIP    = 0;
  localparam int LSA_ERR_W       = 4;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LSA_MODE_ONESHOT = 4'h1;
  localparam logic [3:0] LSA_MODE_CONT    = 4'h2;
  localparam logic [3:0] LSA_MODE_MONITOR = 4'h8;
  localparam logic [3:0] LSA_MODE_OS_MON  = 4'h9;

  typedef enum logic [1:0] {
    LSA_ST_IDLE  = 2'b00,
    LSA_ST_WAIT  = 2'b01,
    LSA_ST_ALIGN = 2'b11,
    LSA_ST_MON   = 2'b10
  } lsa_state_type;

  typedef struct packed {
    logic       enable;
    logic       arm;
    logic       sticky_flag_clear;
    logic [1:0] tolerance_window;
    logic [3:0] align_mode_code;
  } lsa_ctrl_type;

  typedef struct packed {
    logic       busy;
    logic       locked;
    logic       clock_rotated_flag;
    logic       window_limit_flag;
    logic       armed_pulse_seen_flag;
  } lsa_flags_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] error;
    logic       under;
    logic       over;
  } lsa_last_type;

endpackage : lsa_pkg

// ### design/lsa_sync3.sv
// Three-stage synchroniser with agreement filter for an external pin
`timescale 1ns/1ps
`default_nettype none
module lsa_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] sr_q;
  logic [2:0] sr_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb begin
    sr_d  = {sr_q[1:0], pin_in};
    lvl_d = lvl_q;
    // Stage 0 is only fed forward; stages 1 and 2 must agree
    if (sr_q[1] == sr_q[2]) begin
      lvl_d = sr_q[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sr_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sr_q  <= sr_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule // lsa_sync3
`default_nettype wire

// ### design/lmfc_sysref_align_status.sv
// LMFC to SYSREF alignment: phase measurement, adjustment and status registers
`timescale 1ns/1ps
`default_nettype none
module lmfc_sysref_align_status #(
  parameter int LMFC_PERIOD = 16
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  sysref_pin,
  input  wire lsa_pkg::lsa_ctrl_type ctrl,
  input  wire logic [11:0]           reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic [7:0]                 reg_rdata,
  output logic                       lmfc_edge,
  output lsa_pkg::lsa_last_type      phase_error_last_reg,
  output logic [7:0]                 phase_error_now_reg
);
  import lsa_pkg::*;

  // Below four cycles the signed error has too few bits for the 4-bit field
  if (LMFC_PERIOD < 4 || LMFC_PERIOD > 256) begin : g_period_check
    $error("LMFC_PERIOD out of range");
  end

  localparam int CW = $clog2(LMFC_PERIOD);

  // ----------------------------------------------------------------
  // Reference pulse capture
  // ----------------------------------------------------------------
  logic sysref_lvl;
  logic sysref_prev_q;
  logic sysref_rise;

  lsa_sync3 u_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_in    (sysref_pin),
    .level_out (sysref_lvl)
  );

  assign sysref_rise = sysref_lvl & ~sysref_prev_q;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lsa_state_type state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          rot_q, rot_d;
  logic          trip_q, trip_d;
  logic          wlim_q, wlim_d;
  logic          lock_q, lock_d;
  logic [3:0]    err_q, err_d;
  lsa_last_type  last_q, last_d;
  logic          arm_prev_q;
  logic          clr_prev_q;
  logic          armed_q, armed_d;

  logic          arm_rise;
  logic          clr_rise;
  logic signed [CW+1:0] meas;
  logic signed [CW+1:0] win;
  logic          outside;
  logic          adjust;
  logic [3:0]    meas4;

  assign arm_rise  = ctrl.arm & ~arm_prev_q;
  assign clr_rise  = ctrl.sticky_flag_clear & ~clr_prev_q;
  assign lmfc_edge = (cnt_q == '0);

  always_comb begin
    // Signed distance from the nearest LMFC edge to the pulse
    if (cnt_q < CW'(LMFC_PERIOD / 2)) begin
      meas = $signed({2'b00, cnt_q});
    end else begin
      meas = $signed({2'b00, cnt_q}) - (CW+2)'(LMFC_PERIOD);
    end
    win     = $signed({{CW{1'b0}}, ctrl.tolerance_window});
    outside = (meas > win) || (meas < -win);
    // Saturate to the 4-bit field; wider errors still read as limits
    if (meas > (CW+2)'(7)) begin
      meas4 = 4'h7;
    end else if (meas < -(CW+2)'(8)) begin
      meas4 = 4'h8;
    end else begin
      meas4 = meas[3:0];
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q == CW'(LMFC_PERIOD - 1)) ? '0 : cnt_q + CW'(1);
    rot_d   = rot_q;
    trip_d  = trip_q;
    wlim_d  = wlim_q;
    lock_d  = lock_q;
    err_d   = err_q;
    last_d  = last_q;
    armed_d = armed_q | arm_rise;
    adjust  = 1'b0;
    if (clr_rise) begin
      rot_d  = 1'b0;
      trip_d = 1'b0;
    end
    if (!ctrl.enable) begin
      state_d = LSA_ST_IDLE;
      lock_d  = 1'b0;
      armed_d = 1'b0;
    end else begin
      unique case (state_q)
        LSA_ST_IDLE: begin
          if (ctrl.align_mode_code == LSA_MODE_CONT) begin
            state_d = LSA_ST_WAIT;
          end else if (ctrl.align_mode_code == LSA_MODE_MONITOR) begin
            state_d = LSA_ST_MON;
          end else if (armed_d && (ctrl.align_mode_code == LSA_MODE_ONESHOT ||
                                   ctrl.align_mode_code == LSA_MODE_OS_MON)) begin
            state_d = LSA_ST_WAIT;
          end
        end
        LSA_ST_WAIT, LSA_ST_MON: begin
          if (sysref_rise) begin
            if (armed_q) begin
              trip_d  = 1'b1;
              armed_d = 1'b0;
            end
            wlim_d = outside;
            err_d  = meas4;
            if (state_q == LSA_ST_WAIT && outside) begin
              adjust  = 1'b1;
              state_d = LSA_ST_ALIGN;
            end else begin
              lock_d = ~outside;
              if (state_q == LSA_ST_WAIT && ctrl.align_mode_code != LSA_MODE_CONT) begin
                state_d = (ctrl.align_mode_code == LSA_MODE_OS_MON) ? LSA_ST_MON
                                                                    : LSA_ST_IDLE;
              end
            end
          end
        end
        LSA_ST_ALIGN: begin
          lock_d = 1'b1;
          wlim_d = 1'b0;
          if (ctrl.align_mode_code == LSA_MODE_CONT) begin
            state_d = LSA_ST_WAIT;
          end else if (ctrl.align_mode_code == LSA_MODE_OS_MON) begin
            state_d = LSA_ST_MON;
          end else begin
            state_d = LSA_ST_IDLE;
          end
        end
      endcase
    end
    if (adjust) begin
      cnt_d        = CW'(1);    // Pulse now marks the LMFC edge
      rot_d        = 1'b1;
      last_d.valid = 1'b1;
      last_d.error = meas4;
      last_d.under = meas < -win;
      last_d.over  = meas > win;
      err_d        = 4'h0;
      lock_d       = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q       <= LSA_ST_IDLE;
      cnt_q         <= '0;
      rot_q         <= 1'b0;
      trip_q        <= 1'b0;
      wlim_q        <= 1'b0;
      lock_q        <= 1'b0;
      err_q         <= 4'h0;
      last_q        <= '0;
      armed_q       <= 1'b0;
      arm_prev_q    <= 1'b0;
      clr_prev_q    <= 1'b0;
      sysref_prev_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      rot_q         <= rot_d;
      trip_q        <= trip_d;
      wlim_q        <= wlim_d;
      lock_q        <= lock_d;
      err_q         <= err_d;
      last_q        <= last_d;
      armed_q       <= armed_d;
      arm_prev_q    <= ctrl.arm;
      clr_prev_q    <= ctrl.sticky_flag_clear;
      sysref_prev_q <= sysref_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Register read side
  // ----------------------------------------------------------------
  logic [7:0] status_d, status_q;
  logic [7:0] rdata_d, rdata_q;

  always_comb begin
    status_d                  = LSA_STATUS_RST;
    status_d[LSA_BIT_BUSY]    = (state_q != LSA_ST_IDLE);
    status_d[LSA_BIT_LOCK]    = lock_q;
    status_d[LSA_BIT_ROTATED] = rot_q;
    status_d[LSA_BIT_WLIM]    = wlim_q;
    status_d[LSA_BIT_TRIP]    = trip_q;
    // Writes are not decoded at all; reg_wr and reg_wdata have no effect
    unique case (reg_addr)
      LSA_ADDR_STATUS:  rdata_d = status_d;
      LSA_ADDR_ERR_NOW: rdata_d = {4'h0, err_d};
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= LSA_STATUS_RST;
      rdata_q  <= 8'h00;
    end else begin
      status_q <= status_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata            = rdata_q;
  assign phase_error_last_reg = last_q;
  assign phase_error_now_reg  = {4'h0, err_q};

  logic unused_ok;
  assign unused_ok = reg_wr ^ (^reg_wdata) ^ (^status_q);
endmodule // lmfc_sysref_align_status
`default_nettype wire

// ### tb/lsa_asserts.sv
// Checker: port properties of the alignment status block
`timescale 1ns/1ps
`default_nettype none
module lsa_asserts #(
  parameter int LMFC_PERIOD = 16
) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  sysref_pin,
  input wire lsa_pkg::lsa_ctrl_type ctrl,
  input wire logic [11:0]           reg_addr,
  input wire logic [7:0]            reg_rdata,
  input wire lsa_pkg::lsa_last_type phase_error_last_reg,
  input wire logic [7:0]            phase_error_now_reg
);
  import lsa_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  // Pin quiet long enough that no pulse is still inside the synchroniser
  always_comb quiet_d = (rst || sysref_pin) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
  always_ff @(posedge clk_sys) quiet_q <= quiet_d;
  rsvd_zero_a: assert property (
    $past(reg_addr) == LSA_ADDR_STATUS |-> reg_rdata[6:4] == 3'h0)
    else $error("status reserved bits set");
  err_read_a: assert property (
    $past(reg_addr) == LSA_ADDR_ERR_NOW |-> reg_rdata == phase_error_now_reg)
    else $error("error read differs from register");
  err_upper_a: assert property (phase_error_now_reg[7:4] == 4'h0)
    else $error("current error upper bits set");
  adjust_zero_a: assert property (
    $changed(phase_error_last_reg) |-> phase_error_now_reg == 8'h00)
    else $error("current error not cleared on adjust");
  rotate_set_a: assert property (
    $changed(phase_error_last_reg) ##1 reg_addr == LSA_ADDR_STATUS |=> reg_rdata[2])
    else $error("rotated flag missing after adjust");
  lock_wlim_a: assert property (
    $past(reg_addr) == LSA_ADDR_STATUS |-> !(reg_rdata[3] && reg_rdata[1]))
    else $error("lock and window limit together");
  idle_busy_a: assert property (
    !$past(ctrl.enable, 2) && !$past(ctrl.enable) && $past(reg_addr) == LSA_ADDR_STATUS
    |-> !reg_rdata[7]) else $error("busy while disabled");
  sticky_clr_a: assert property (
    $rose(ctrl.sticky_flag_clear) && quiet_q > 4'h8 ##1 reg_addr == LSA_ADDR_STATUS
    |=> reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0) else $error("sticky flags kept");
endmodule // lsa_asserts

bind lmfc_sysref_align_status lsa_asserts #(.LMFC_PERIOD(LMFC_PERIOD)) u_lsa_asserts (
  .clk_sys(clk_sys), .rst(rst), .sysref_pin(sysref_pin), .ctrl(ctrl), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .phase_error_last_reg(phase_error_last_reg),
  .phase_error_now_reg(phase_error_now_reg));
`default_nettype wire

// ### tb/lsa_sysref_src.sv
// Reference pulse source driving the external alignment pin
`timescale 1ns/1ps
`default_nettype none
module lsa_sysref_src #(
  parameter int PERIOD = 16
) (
  input  wire logic clk_sys,
  output var logic  sysref_pin
);
  int unsigned cyc_q = 0;
  int unsigned t0 = 0;
  initial sysref_pin = 1'b0;
  always @(posedge clk_sys) cyc_q <= cyc_q + 1;
  // A late caller is pushed out by whole periods so the intended phase holds
  task automatic fire(input int unsigned gap);
    int unsigned tgt;
    tgt = t0 + gap;
    while (tgt <= cyc_q) tgt += PERIOD;
    while (cyc_q < tgt) begin
      @(posedge clk_sys);
      #1;
    end
    t0 = tgt;
    sysref_pin = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 sysref_pin = 1'b0;
  endtask
endmodule // lsa_sysref_src
`default_nettype wire

// ### tb/test_lmfc_sysref_align_status.sv
// Self-checking bench for the alignment status block
`timescale 1ns/1ps
`default_nettype none
module test_lmfc_sysref_align_status;
  import lsa_pkg::*;
  localparam int P = 16;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  lsa_ctrl_type ctrl = '0;
  logic [11:0]  reg_addr = 12'h000;
  logic         reg_wr = 1'b0;
  logic [7:0]   reg_wdata = 8'h00;
  logic [7:0]   reg_rdata;
  logic [7:0]   rd_v;
  logic         sysref_pin;
  logic         lmfc_edge;
  lsa_last_type last;
  int           n_mismatch = 0;
  int           num_checks = 0;
  int           d;
  int           w;
  logic         rot;

  always #20 clk_sys = ~clk_sys;
  lsa_sysref_src #(.PERIOD(P)) u_lsa_sysref_src (.clk_sys(clk_sys), .sysref_pin(sysref_pin));
  lmfc_sysref_align_status #(.LMFC_PERIOD(P)) u_lmfc_sysref_align_status (
    .clk_sys(clk_sys), .rst(rst), .sysref_pin(sysref_pin), .ctrl(ctrl),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lmfc_edge(lmfc_edge), .phase_error_last_reg(last), .phase_error_now_reg());

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_status(input logic b, lk, r, wl, t);
    return {b, 3'h0, lk, r, wl, t};
  endfunction
  function automatic logic out_win(input int e, input int win);
    return (e > win) || (-e > win);
  endfunction
  // A write rides along with every read; the registers must shrug it off
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = 8'($urandom);
    @(posedge clk_sys);
    #1;
    rd_v = reg_rdata;
    reg_wr = 1'b0;
  endtask
  task automatic pulse(input int g);
    u_lsa_sysref_src.fire(g);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  // Monitor is left only through idle, so each phase restarts there before realigning
  task automatic prep(input logic [3:0] m);
    ctrl.align_mode_code = LSA_MODE_CONT;
    ctrl.tolerance_window = 2'h0;
    ctrl.enable = 1'b0;
    @(posedge clk_sys);
    #1;
    ctrl.enable = 1'b1;
    pulse(4 * P);
    repeat (8) @(posedge clk_sys);
    #1;
    chk({7'h0, lmfc_edge}, 8'h01, "lmfc edge after align");
    ctrl.align_mode_code = m;
    ctrl.enable = 1'b0;
    ctrl.sticky_flag_clear = 1'b0;
    ctrl.arm = 1'b0;
    @(posedge clk_sys);
    #1;
    ctrl.enable = 1'b1;
    ctrl.sticky_flag_clear = 1'b1;
    ctrl.arm = 1'b1;
    rd(LSA_ADDR_STATUS);
    chk(rd_v & 8'h05, 8'h00, "sticky clear");
  endtask

  initial begin
    void'($urandom(60));
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    ctrl.enable = 1'b1;
    rd(LSA_ADDR_STATUS);
    chk(rd_v, 8'h00, "idle on unknown mode");
    rd(12'h03e);
    chk(rd_v, 8'h00, "unmapped read");
    for (int i = 0; i < 12; i++) begin
      w = int'($urandom_range(3));
      d = int'($urandom_range(14)) - 7;
      if (i == 0) d = w + 1;
      if (i == 1) d = -w;
      prep(LSA_MODE_CONT);
      ctrl.tolerance_window = w[1:0];
      pulse(4 * P);
      rd(LSA_ADDR_STATUS);
      chk(rd_v, exp_status(1'h1, 1'h1, 1'h0, 1'h0, 1'h1), "aligned");
      rd(LSA_ADDR_ERR_NOW);
      chk(rd_v, 8'h00, "zero error");
      pulse(4 * P + d);
      rot = out_win(d, w);
      rd(LSA_ADDR_STATUS);
      chk(rd_v & 8'hfd, exp_status(1'h1, 1'h1, rot, 1'h0, 1'h1), "offset");
      rd(LSA_ADDR_ERR_NOW);
      chk(rd_v, rot ? 8'h00 : {4'h0, 4'(d)}, "now error");
      if (rot) chk({4'h0, last.error}, {4'h0, 4'(d)}, "last error");
      if (rot) chk({5'h0, last.valid, last.under, last.over}, {5'h0, 1'b1, d < 0, d > 0}, "last flags");
    end
    for (int k = 0; k < 2; k++) begin
      prep(k ? LSA_MODE_OS_MON : LSA_MODE_ONESHOT);
      pulse(4 * P + 5);
      chk({4'h0, last.error}, 8'h05, "one-shot adjust");
      pulse(4 * P + 2);
      rd(LSA_ADDR_STATUS);
      chk(rd_v & 8'h82, k ? 8'h82 : 8'h00, "after one-shot");
      rd(LSA_ADDR_ERR_NOW);
      chk(rd_v, k ? 8'h02 : 8'h00, "second pulse");
      chk({4'h0, last.error}, 8'h05, "last kept");
    end
    prep(LSA_MODE_MONITOR);
    pulse(4 * P + 3);
    rd(LSA_ADDR_STATUS);
    chk(rd_v & 8'h06, 8'h02, "monitor limit");
    rd(LSA_ADDR_ERR_NOW);
    chk(rd_v, 8'h03, "monitor error");
    ctrl.enable = 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(LSA_ADDR_STATUS);
    chk(rd_v & 8'h88, 8'h00, "disabled");
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(LSA_ADDR_STATUS);
    chk(rd_v, LSA_STATUS_RST, "status reset");
    rd(LSA_ADDR_ERR_NOW);
    chk(rd_v, LSA_ERR_NOW_RST, "error reset");
    summarize();
  end
  // The sequence needs about 2900 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
endmodule // test_lmfc_sysref_align_status
`default_nettype wire
